/* File: core/emp_event_mask.sv */
// event interrupt mask, sticky status and phase attribution with AXI4-Lite slave
// assumes detectors on sys_clk_i deliver pulses and levels; no synchronisers needed
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "emp_regs.svh"
module emp_event_mask #(
  parameter int ADDR_W      = 18,  // AXI address width
  parameter int SAMPLE_W    = 28,  // width of current samples
  parameter bit FUND_METER  = 1'b1 // fundamental metering present
) (
  input  wire logic                sys_clk_i,     // block clock, 250 MHz
  input  wire logic                srst_i,        // sync reset, high
  input  wire emp_pkg::emp_evt_t   evt_i,         // detector events
  input  wire logic [SAMPLE_W-1:0] sum_cur_i,     // summed phase current
  input  wire logic [SAMPLE_W-1:0] neut_cur_i,    // neutral current sample
  input  wire logic                cur_valid_i,   // both samples valid
  input  wire logic [ADDR_W-1:0]   s_awaddr_i,    // write address
  input  wire logic                s_awvalid_i,   // write address valid
  output logic                     s_awready_o,   // write address ready
  input  wire logic [31:0]         s_wdata_i,     // write data
  input  wire logic [3:0]          s_wstrb_i,     // byte enables
  input  wire logic                s_wvalid_i,    // write data valid
  output logic                     s_wready_o,    // write data ready
  output logic [1:0]               s_bresp_o,     // write response
  output logic                     s_bvalid_o,    // write response valid
  input  wire logic                s_bready_i,    // response taken
  input  wire logic [ADDR_W-1:0]   s_araddr_i,    // read address
  input  wire logic                s_arvalid_i,   // read address valid
  output logic                     s_arready_o,   // read address ready
  output logic [31:0]              s_rdata_o,     // read data
  output logic [1:0]               s_rresp_o,     // read response
  output logic                     s_rvalid_o,    // read data valid
  input  wire logic                s_rready_i,    // read data taken
  output logic                     irq_o          // level interrupt, high
);
  import emp_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < 18) begin : g_bad_addr
    $error("ADDR_W must reach the highest register");
  end
  // the widened difference must leave at least one pad bit in a 32-bit word
  if (SAMPLE_W < 2 || SAMPLE_W > 30) begin : g_bad_sample
    $error("SAMPLE_W out of range");
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // byte-enable merge, used for every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // byte address of a register index
  function automatic logic [17:0] addr_of(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : addr_of

  // absolute difference of two signed samples, one bit wider
  function automatic logic [SAMPLE_W:0] abs_diff(input logic [SAMPLE_W-1:0] a,
                                                 input logic [SAMPLE_W-1:0] b);
    logic signed [SAMPLE_W:0] d;
    d = $signed({a[SAMPLE_W-1], a}) - $signed({b[SAMPLE_W-1], b});
    return d[SAMPLE_W] ? (SAMPLE_W+1)'(0) - d : d;
  endfunction : abs_diff

  emp_state_t  st_q;
  emp_state_t  st_d;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] eff_mask;
  logic [17:0] ar_a;
  logic [17:0] wr_a;
  logic        do_wr;
  logic        mism;

  // ------------------------------------------------------------------
  // event collection
  // ------------------------------------------------------------------
  // no-load interrupts fire on entry only, so hold last level per phase;
  // differencing the sample pair one bit wider avoids overflow wraps
  always_comb begin
    set_v = `EMP_RST_WORD;
    mism  = cur_valid_i &&
            ({{(32-SAMPLE_W-1){1'b0}}, abs_diff(sum_cur_i, neut_cur_i)}
             > st_q.thr);
    set_v[`EMP_B_NL_TOT]  = |(evt_i.nl_tot & ~st_q.nl_tot);
    set_v[`EMP_B_NL_FUND] = FUND_METER &&
                            |(evt_i.nl_fund & ~st_q.nl_fund);
    set_v[`EMP_B_NL_APP]  = |(evt_i.nl_app & ~st_q.nl_app);
    set_v[`EMP_B_ZC_TO +: 6]   = evt_i.zc_timeout;
    set_v[`EMP_B_ZC_SEEN +: 6] = evt_i.zc_seen;
    set_v[`EMP_B_RESET_FINISHED_IRQ] = evt_i.reset_done;
    set_v[`EMP_B_DIP]     = evt_i.dip;
    set_v[`EMP_B_OVI]     = evt_i.ovi;
    set_v[`EMP_B_OVV]     = evt_i.ovv;
    set_v[`EMP_B_SEQ]     = (st_q.seq == EMP_SQ_ARMED) &&
                            evt_i.v_rise[2] && !evt_i.v_rise[1];
    set_v[`EMP_B_MISM]    = mism;
    set_v[`EMP_B_PKI]     = evt_i.pk_i_end;
    set_v[`EMP_B_PKV]     = evt_i.pk_v_end;
  end

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign ar_a  = s_araddr_i[17:0];
  assign wr_a  = st_q.aw_addr;
  assign do_wr = st_q.aw_have && st_q.w_have && !st_q.bvalid;
  // write-one-to-clear on status, only the enabled bytes
  assign clr_v = (do_wr && wr_a == addr_of(`EMP_STAT_IDX)) ?
                 merge(`EMP_RST_WORD, st_q.wdata, st_q.wstrb) : `EMP_RST_WORD;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // level history for entry detection
    st_d.nl_tot  = evt_i.nl_tot;
    st_d.nl_fund = evt_i.nl_fund;
    st_d.nl_app  = evt_i.nl_app;

    // phase order: A rising arms, B next is healthy, C next is a fault
    case (st_q.seq)
      EMP_SQ_IDLE: begin
        if (evt_i.v_rise[0]) st_d.seq = EMP_SQ_ARMED;
      end
      EMP_SQ_ARMED: begin
        if (evt_i.v_rise[1] || evt_i.v_rise[2]) begin
          st_d.seq = evt_i.v_rise[0] ? EMP_SQ_ARMED : EMP_SQ_IDLE;
        end
      end
      default: st_d.seq = EMP_SQ_IDLE;
    endcase

    // sticky status: a new event wins over a clear in the same cycle
    st_d.status = ((st_q.status & ~clr_v) | set_v) & `EMP_IMPL_MASK;

    // attribution follows its status bit: cleared with it, set with events
    if (clr_v[`EMP_B_OVI]) st_d.phsrc[`EMP_PH_OVI +: 3] = 3'h0;
    if (clr_v[`EMP_B_OVV]) st_d.phsrc[`EMP_PH_OVV +: 3] = 3'h0;
    if (clr_v[`EMP_B_DIP]) st_d.phsrc[`EMP_PH_DIP +: 3] = 3'h0;
    if (evt_i.ovi) begin
      st_d.phsrc[`EMP_PH_OVI +: 3] = st_d.phsrc[`EMP_PH_OVI +: 3] | evt_i.ovi_ph;
    end
    if (evt_i.ovv) begin
      st_d.phsrc[`EMP_PH_OVV +: 3] = st_d.phsrc[`EMP_PH_OVV +: 3] | evt_i.ovv_ph;
    end
    if (evt_i.dip) begin
      st_d.phsrc[`EMP_PH_DIP +: 3] = st_d.phsrc[`EMP_PH_DIP +: 3] | evt_i.dip_ph;
    end
    st_d.phsrc = st_d.phsrc & `EMP_PH_IMPL;

    // write address and data are taken independently, in either order
    if (s_awvalid_i && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_awaddr_i[17:0];
    end
    if (s_wvalid_i && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = s_wdata_i;
      st_d.wstrb  = s_wstrb_i;
    end

    // perform the write once both halves are held
    if (do_wr) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `EMP_RESP_OKAY;
      case (wr_a)
        addr_of(`EMP_MASK_IDX): begin
          // bit 15 is stored but gates nothing; reserved bits stay zero
          st_d.mask = merge(st_q.mask, st_q.wdata, st_q.wstrb)
                      & `EMP_IMPL_MASK;
        end
        addr_of(`EMP_THR_IDX): begin
          st_d.thr = merge(st_q.thr, st_q.wdata, st_q.wstrb);
        end
        addr_of(`EMP_STAT_IDX): begin
          st_d.bresp = `EMP_RESP_OKAY;
        end
        addr_of(`EMP_PHSRC_IDX): begin
          st_d.bresp = `EMP_RESP_OKAY;                            // read-only, ignored
        end
        default: st_d.bresp = `EMP_RESP_SLV;
      endcase
    end else if (st_q.bvalid && s_bready_i) begin
      st_d.bvalid = 1'b0;
    end

    // reads answer one cycle after the address is taken
    if (s_arvalid_i && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `EMP_RESP_OKAY;
      case (ar_a)
        addr_of(`EMP_MASK_IDX):  st_d.rdata = st_q.mask;
        addr_of(`EMP_STAT_IDX):  st_d.rdata = st_q.status;
        addr_of(`EMP_THR_IDX):   st_d.rdata = st_q.thr;
        addr_of(`EMP_PHSRC_IDX): st_d.rdata = {16'h0000, st_q.phsrc};
        default: begin
          st_d.rdata = `EMP_RST_WORD;
          st_d.rresp = `EMP_RESP_SLV;
        end
      endcase
    end else if (st_q.rvalid && s_rready_i) begin
      st_d.rvalid = 1'b0;
    end

    // one transaction per direction: ready again only when idle
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready  = !st_d.w_have && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;

    // effective gate: reset-done always on, fundamental bit dropped if absent;
    // kept in this process so the next-state record feeds no second process
    eff_mask = st_d.mask & `EMP_IMPL_MASK;
    eff_mask[`EMP_B_RESET_FINISHED_IRQ] = 1'b1;
    if (!FUND_METER) eff_mask[`EMP_B_NL_FUND] = 1'b0;

    // interrupt from the next state so the pin is a plain flop
    st_d.irq = |(st_d.status & eff_mask);
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q     <= '0;
      st_q.seq <= EMP_SQ_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign s_awready_o = st_q.awready;
  assign s_wready_o  = st_q.wready;
  assign s_bvalid_o  = st_q.bvalid;
  assign s_bresp_o   = st_q.bresp;
  assign s_arready_o = st_q.arready;
  assign s_rvalid_o  = st_q.rvalid;
  assign s_rdata_o   = st_q.rdata;
  assign s_rresp_o   = st_q.rresp;
  assign irq_o       = st_q.irq;
endmodule : emp_event_mask

/* File: core/emp_pkg.sv */
// types of the event mask block: event carrier, sequence states, state record
// assumes emp_regs.svh sits beside it
package emp_pkg;
  `include "emp_regs.svh"

  // three phase flags, bit 0 phase A
  typedef logic [2:0] emp_phase_t;

  // event inputs from the metering detectors, same clock
  typedef struct packed {
    emp_phase_t nl_tot;       // no-load level per phase, total power
    emp_phase_t nl_fund;      // no-load level per phase, fundamental
    emp_phase_t nl_app;       // no-load level per phase, apparent
    logic [5:0] zc_timeout;   // missing crossing pulses VA..IC
    logic [5:0] zc_seen;      // crossing pulses VA..IC
    logic       reset_done;   // reset finished pulse
    logic       dip;          // voltage dip pulse
    emp_phase_t dip_ph;       // phases behind the dip
    logic       ovi;          // excess current pulse
    emp_phase_t ovi_ph;       // phases behind it
    logic       ovv;          // high line pulse
    emp_phase_t ovv_ph;       // phases behind it
    emp_phase_t v_rise;       // rising voltage crossings A,B,C
    logic       pk_i_end;     // current peak period over
    logic       pk_v_end;     // voltage peak period over
  } emp_evt_t;

  // phase order watcher, one-hot
  typedef enum logic [1:0] {
    EMP_SQ_IDLE  = 2'b01,
    EMP_SQ_ARMED = 2'b10
  } emp_seq_t;

  // whole state of the block
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] status;
    logic [15:0] phsrc;
    logic [31:0] thr;
    emp_phase_t  nl_tot;
    emp_phase_t  nl_fund;
    emp_phase_t  nl_app;
    emp_seq_t    seq;
    logic        aw_have;
    logic        w_have;
    logic [17:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        irq;
  } emp_state_t;
endpackage : emp_pkg

/* File: core/emp_regs.svh */
// register map, field positions and reset values of the event mask block
// assumes inclusion by core/emp_pkg.sv and the block file by bare name
// Notes on behaviour
// - mask bit 0 enables interrupt when any phase enters no-load on total power.
// - mask bit 1 enables fundamental no-load interrupt; ignored without fundamental metering.
// - mask bit 2 enables interrupt when any phase enters no-load on apparent power.
// - mask bits 3-8 enable missing zero crossing: VA, VB, VC, IA, IB, IC.
// - mask bits 9-14 enable detected zero crossing: VA, VB, VC, IA, IB, IC.
// - mask bit 15 is writable but inert; reset-done interrupt is never masked.
// - mask bit 16 enables voltage dip interrupt; phase shown in attribution bits 14:12.
// - mask bit 17 enables excess current interrupt; phase shown in bits 5:3.
// - mask bit 18 enables high line interrupt; phase shown in bits 11:9.
// - mask bit 19 enables interrupt when rising VA is followed by VC, not VB.
// - mask bit 20 enables interrupt when |summed current - neutral| exceeds threshold.
// - mask bits 22:21 and 31:25 are reserved, zero, and control nothing.
// - mask bit 23 enables interrupt at end of current peak period.
// - mask bit 24 enables interrupt at end of voltage peak period.
// - attribution bits 3,4,5 mark phase A,B,C current causing excess current.
// - attribution bits 9,10,11 mark phase A,B,C voltage causing high line.
// - attribution bits 12,13,14 mark phase A,B,C voltage causing voltage dip.
// - attribution bits 2:0, 8:6 and 15 are reserved and read zero.
`ifndef EMP_REGS_SVH
`define EMP_REGS_SVH
// register indices; byte address is four times the index
`define EMP_MASK_IDX   16'hE50B
`define EMP_PHSRC_IDX  16'hE600
`define EMP_STAT_IDX   16'hE502
`define EMP_THR_IDX    16'hE510
// status and mask bit positions
`define EMP_B_NL_TOT   0
`define EMP_B_NL_FUND  1
`define EMP_B_NL_APP   2
`define EMP_B_ZC_TO    3
`define EMP_B_ZC_SEEN  9
`define EMP_B_RESET_FINISHED_IRQ  15
`define EMP_B_DIP      16
`define EMP_B_OVI      17
`define EMP_B_OVV      18
`define EMP_B_SEQ      19
`define EMP_B_MISM     20
`define EMP_B_PKI      23
`define EMP_B_PKV      24
// implemented bits of mask and status; the rest is reserved
`define EMP_IMPL_MASK  32'h019F_FFFF
// attribution field low bits and implemented bits
`define EMP_PH_OVI     3
`define EMP_PH_OVV     9
`define EMP_PH_DIP     12
`define EMP_PH_IMPL    16'h7E38
// reset values and bus answers
`define EMP_RST_WORD   32'h0000_0000
`define EMP_RESP_OKAY  2'h0
`define EMP_RESP_SLV   2'h2
`endif

/* File: testbench/emp_event_mask_asserts.sv */
// checker of the event mask block, bound onto every emp_event_mask instance
// assumes emp_pkg and its register map macros are compiled first
`timescale 1ns/1ps
`include "emp_regs.svh"
module emp_event_mask_asserts #(
  parameter int ADDR_W = 18                  // AXI address width
) (
  input wire logic              sys_clk_i,   // block clock
  input wire logic              srst_i,      // sync reset, high
  input wire emp_pkg::emp_evt_t evt_i,       // detector events
  input wire logic [ADDR_W-1:0] s_araddr_i,  // read address
  input wire logic              s_arvalid_i, // read address valid
  input wire logic              s_arready_o, // read address ready
  input wire logic [31:0]       s_rdata_o,   // read data
  input wire logic [1:0]        s_rresp_o,   // read response
  input wire logic              s_rvalid_o,  // read data valid
  input wire logic              s_rready_i,  // read data taken
  input wire logic [1:0]        s_bresp_o,   // write response
  input wire logic              s_bvalid_o,  // write response valid
  input wire logic              s_bready_i,  // response taken
  input wire logic              irq_o        // level interrupt
);
  import emp_pkg::*;
  // ----------------------------------------------------------------
  // read address tracking
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] ar_q;
  // remember the address taken so read data can be judged by register
  always_ff @(posedge sys_clk_i) begin
    if (s_arvalid_i && s_arready_o) ar_q <= s_araddr_i;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_rst_quiet: assert property (disable iff (1'b0)
    srst_i |=> !irq_o && !s_rvalid_o && !s_bvalid_o) else $error("outputs busy after reset");
  chk_rd_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("read data not one cycle after address");
  chk_rd_hold: assert property (s_rvalid_o && !s_rready_i |=>
    s_rvalid_o && $stable(s_rdata_o) && $stable(s_rresp_o)) else $error("read data moved");
  chk_b_hold: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response moved");
  chk_reset_finished_irq_irq: assert property (evt_i.reset_done |=> irq_o)
    else $error("reset done did not interrupt");
  chk_irq_sticky: assert property (irq_o |=> irq_o || $rose(s_bvalid_o))
    else $error("interrupt fell without a write");
  chk_src_rsvd: assert property (s_rvalid_o && ar_q == {`EMP_PHSRC_IDX, 2'h0} |->
    (s_rdata_o & ~32'h0000_7E38) == 32'h0) else $error("attribution reserved bit set");
  chk_mask_rsvd: assert property (s_rvalid_o && ar_q == {`EMP_MASK_IDX, 2'h0} |->
    s_rdata_o[31:25] == 7'h00 && s_rdata_o[22:21] == 2'h0) else $error("mask reserved bit set");
  cover property ($rose(irq_o));
  cover property (s_bvalid_o && s_bresp_o == 2'h2);
  cover property (s_rvalid_o && s_rresp_o == 2'h2);
endmodule : emp_event_mask_asserts

bind emp_event_mask emp_event_mask_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: testbench/tb_top.sv */
// self-checking bench of the event mask block over AXI4-Lite
// assumes emp_pkg, the design and the checker are compiled before it
`timescale 1ns/1ps
`include "emp_regs.svh"
module tb_top;
  import emp_pkg::*;
  localparam logic [17:0] A_MASK = {`EMP_MASK_IDX, 2'h0};
  localparam logic [17:0] A_PH   = {`EMP_PHSRC_IDX, 2'h0};
  localparam logic [17:0] A_ST   = {`EMP_STAT_IDX, 2'h0};
  localparam logic [17:0] A_THR  = {`EMP_THR_IDX, 2'h0};
  logic clk, srst, cur_valid, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [27:0] sum_cur, neut_cur;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  emp_evt_t    evt;
  int          failures, checks;
  logic [33:0] q[$];
  string       nq[$];

  emp_event_mask u_emp_event_mask (.sys_clk_i(clk), .srst_i(srst), .evt_i(evt),
    .sum_cur_i(sum_cur), .neut_cur_i(neut_cur), .cur_valid_i(cur_valid),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
    .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp),
    .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready), .irq_o(irq));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // every bus answer takes the oldest note off the queue
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk(nq.pop_front(), q.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) chk(nq.pop_front(), q.pop_front(), {bresp, 32'h0});
  end

  // ----------------------------------------------------------------
  // bus and event drivers
  // ----------------------------------------------------------------
  task automatic wr(logic [17:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    q.push_back({r, 32'h0});
    nq.push_back("bresp");
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awvalid && awready) begin aw = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
  endtask : wr

  task automatic rd(logic [17:0] a, logic [31:0] e, string nm, logic [1:0] r = 2'h0);
    q.push_back({r, e});
    nq.push_back(nm);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
  endtask : rd

  task automatic irqc(logic e);
    @(negedge clk);
    chk("irq", {33'h0, e}, {33'h0, irq});
    // hand back on a rising edge so the next request starts there
    @(posedge clk);
  endtask : irqc

  // one event of status bit b; phases p where the event has them
  task automatic fire(int b, logic [2:0] p);
    emp_evt_t e;
    e = '0;
    case (b)
      0: e.nl_tot = p;
      1: e.nl_fund = p;
      2: e.nl_app = p;
      15: e.reset_done = 1'b1;
      16: begin e.dip = 1'b1; e.dip_ph = p; end
      17: begin e.ovi = 1'b1; e.ovi_ph = p; end
      18: begin e.ovv = 1'b1; e.ovv_ph = p; end
      19: e.v_rise = 3'h1;
      20: cur_valid <= 1'b1;
      23: e.pk_i_end = 1'b1;
      24: e.pk_v_end = 1'b1;
      default: if (b < 9) e.zc_timeout[b-3] = 1'b1; else e.zc_seen[b-9] = 1'b1;
    endcase
    evt <= e;
    @(posedge clk);
    e = '0;
    if (b == 19) e.v_rise = 3'h4;
    evt <= e; cur_valid <= 1'b0;
    @(posedge clk);
    evt <= '0;
  endtask : fire

  function automatic logic [31:0] src(int b, logic [2:0] p);
    return (b == 16) ? {17'h0, p, 12'h0} : (b == 17) ? {26'h0, p, 3'h0} :
           (b == 18) ? {20'h0, p, 9'h0} : 32'h0;
  endfunction : src

  // ----------------------------------------------------------------
  // clock, reset, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    logic [2:0]  p;
    srst = 1'b1; evt = '0; cur_valid = 1'b0; sum_cur = 28'h0000064; neut_cur = 28'h0;
    // the master keeps both answer readies high, so every answer is taken at once
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0; rready = 1'b1;
    awaddr = 18'h0; araddr = 18'h0; wdata = 32'h0; wstrb = 4'hF;
    void'($urandom(32'hD34A2FD7));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(A_MASK, 32'h0, "mask reset");
    rd(A_PH, 32'h0, "source reset");
    rd(A_ST, 32'h0, "status reset");
    rd(18'h00100, 32'h0, "unmapped read", 2'h2);
    wr(18'h00100, 32'hFFFF_FFFF, 2'h2);
    wr(A_PH, 32'hFFFF_FFFF);
    rd(A_PH, 32'h0, "source ignores writes");
    $display("test registers done");
    d = $urandom | 32'h0000_8000;
    wr(A_MASK, d);
    rd(A_MASK, d & `EMP_IMPL_MASK, "mask readback");
    // only the low byte lane is enabled, so the upper threshold bytes stay zero
    wstrb <= 4'h1;
    wr(A_THR, 32'hFFFF_FF64);
    wstrb <= 4'hF;
    rd(A_THR, 32'h0000_0064, "strobed threshold");
    fire(20, 3'h0);
    rd(A_ST, 32'h0, "equal mismatch");
    sum_cur <= 28'h0000065;
    $display("test mask and threshold done");
    for (int b = 0; b < 25; b++) begin
      if (b != 21 && b != 22) begin
        p = 3'($urandom_range(1, 7));
        wr(A_MASK, ~(32'h1 << b));
        fire(b, p);
        irqc(b == 15);
        rd(A_ST, 32'h1 << b, "status bit");
        rd(A_PH, src(b, p), "source");
        wr(A_MASK, 32'h1 << b);
        irqc(1'b1);
        wr(A_ST, 32'h1 << b);
        irqc(1'b0);
        rd(A_PH, 32'h0, "source cleared");
      end
    end
    $display("test events done");
    // rising A then B then C is the correct order
    evt.v_rise <= 3'h1;
    @(posedge clk);
    evt.v_rise <= 3'h2;
    @(posedge clk);
    evt.v_rise <= 3'h4;
    @(posedge clk);
    evt.v_rise <= 3'h0;
    rd(A_ST, 32'h0, "good order");
    $display("test phase order done");
    wrap_up();
  end
endmodule : tb_top
